// ===== src/psmc_defs.svh
// Constants for the phase shedding mode controller
`ifndef PSMC_DEFS_SVH
`define PSMC_DEFS_SVH
`define PSMC_CLK_MHZ         100
`define PSMC_SLEW_STEP_MV    1
`define PSMC_SLEW_NUM_10     40'd1000000
`define PSMC_BODY_DIODE_NS   40
`define PSMC_BODY_DIODE_CYC  ((`PSMC_BODY_DIODE_NS * `PSMC_CLK_MHZ) / 1000)
`define PSMC_THR_RESET       8'h80
`define PSMC_THR_MAX         8'hFF
`define PSMC_VOUT_RESET      8'h00
`define PSMC_PS_FULL         2'h3
`define PSMC_PS_HALF         2'h1
`define PSMC_PS_LIGHT        2'h0
`define PSMC_SLEW_10         2'h0
`define PSMC_SLEW_12P5       2'h1
`define PSMC_SLEW_15         2'h2
`define PSMC_SLEW_20         2'h3
// Slew periods: clock cycles per 6.25 mV code step (100 MHz)
`define PSMC_STEP_UV         6250
`define PSMC_PER_10          ((`PSMC_STEP_UV * `PSMC_CLK_MHZ) / 10000)
`define PSMC_PER_12P5        ((`PSMC_STEP_UV * `PSMC_CLK_MHZ * 10) / 125000)
`define PSMC_PER_15          ((`PSMC_STEP_UV * `PSMC_CLK_MHZ) / 15000)
`define PSMC_PER_20          ((`PSMC_STEP_UV * `PSMC_CLK_MHZ) / 20000)
`endif

// ===== src/psmc_pkg.sv
// Types for the phase shedding mode controller
package psmc_pkg;
    typedef enum logic [1:0] {PSMC_START, PSMC_RUN} psmc_state_e;
    typedef enum logic [1:0] {PSMC_LS_IDLE, PSMC_LS_ON, PSMC_LS_WATCH} psmc_ls_e;
    typedef logic [2:0] psmc_phases_t;
endpackage

// ===== src/psmc_ramp.sv
// Reference ramp toward a target voltage code, rising at a fixed step period
`include "psmc_defs.svh"
module psmc_ramp (
    input  wire logic       clock,      // System clock
    input  wire logic       rst_n,      // Async reset, active low
    input  wire logic       step_en,    // One-cycle slew enable
    input  wire logic [7:0] target,     // Target voltage code
    output logic      [7:0] ref_code    // Present reference code
);
    // Rising codes step at the slew rate; falling codes follow at once since
    // the output is left to decay under load rather than being pulled down
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_code <= `PSMC_VOUT_RESET;
        end else if (target < ref_code) begin
            ref_code <= target;
        end else if (step_en && target > ref_code) begin
            ref_code <= ref_code + 8'h01;
        end
    end
endmodule

// ===== src/psmc_mode_ctrl.sv
// Phase shedding mode controller: configuration, modes, slew, low-side timing
//
// Contract
// - Sense pin at 5V disables that core channel
// - Four-channel core: 11 four, 01 two, 00 light
// - Three-channel core: 11 three, 01 two continuous
// - Three-channel core: 00 one phase light load
// - Two-channel core: 11 two, 01 one, 00 light
// - One-channel core: continuous unless both bits low
// - Core channel one at 5V disables core
// - Aux channel two sense sets two or one
// - Two-phase aux: 11 two, 01 one, 00 light
// - One-phase aux: light load only when both low
// - Aux channel one at 5V disables aux
// - Both references ramp at one shared slew rate
// - Downward changes not driven, load sets fall
// - Light load: low side off near zero current; only core_light_load arms it, aux light load has none
// - Phase comparator trip marks the zero crossing
// - Step threshold so body diode conducts near 40ns
// - Slew selection latched at soft-start, then held
`include "psmc_defs.svh"
module psmc_mode_ctrl (
    input  wire logic       clock,                 // 100 MHz clock
    input  wire logic       rst_n,                 // Power-on reset, active low
    input  wire logic       soft_start,            // High during soft-start
    input  wire logic       core_ch1_sense_pin,    // High when tied to 5V
    input  wire logic       core_ch2_sense_pin,    // High when tied to 5V
    input  wire logic       core_ch3_sense_pin,    // High when tied to 5V
    input  wire logic       core_ch4_sense_pin,    // High when tied to 5V
    input  wire logic       aux_ch1_sense_pin,     // High when tied to 5V
    input  wire logic       aux_ch2_sense_pin,     // High when tied to 5V
    input  wire logic       power_state_low_a,     // First power-state bit
    input  wire logic       power_state_low_b,     // Second power-state bit
    input  wire logic [1:0] slew_select,           // Strap slew choice
    input  wire logic [7:0] core_target,           // Core target voltage code
    input  wire logic [7:0] aux_target,            // Aux target voltage code
    input  wire logic       ls_on,                 // Low-side switch gate on
    input  wire logic       phase_below_thr,       // Phase comparator trip
    input  wire logic       body_diode,            // Phase node shows diode drop
    input  wire logic       body_diode_reverse,    // Diode spike, reversed current
    output logic            core_enable,           // Core output enabled
    output logic      [2:0] core_phases,           // Core active phase count
    output logic            core_light_load,       // Core in pulse-skip mode
    output logic            aux_enable,            // Aux output enabled
    output logic      [1:0] aux_phases,            // Aux active phase count
    output logic            aux_light_load,        // Aux in pulse-skip mode
    output logic      [7:0] core_ref,              // Core reference code
    output logic      [7:0] aux_ref,               // Aux reference code
    output logic      [1:0] slew_latched,          // Held slew selection
    output logic            ls_off_req,            // Turn low side off
    output logic      [7:0] zc_threshold,          // Comparator threshold code
    output logic            config_valid           // Configuration latched
);
    ////////////////////////////////////////////////////////////////////////////
    // Start-up sampling
    psmc_pkg::psmc_state_e  state;
    psmc_pkg::psmc_phases_t core_cfg;
    logic                   core_off;
    logic                   aux_two;
    logic                   aux_off;

    // Count of populated channels: a channel is populated until a 5V tie
    function automatic psmc_pkg::psmc_phases_t cfg_count(input logic c2, input logic c3,
                                                         input logic c4);
        psmc_pkg::psmc_phases_t n;
        n = 3'h1;
        if (!c2) begin
            n = 3'h2;
            if (!c3) begin
                n = c4 ? 3'h3 : 3'h4;
            end
        end
        return n;
    endfunction

    // Ties re-sampled every cycle while soft-start runs, then frozen until next start
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= psmc_pkg::PSMC_START;
        end else if (soft_start) begin
            state <= psmc_pkg::PSMC_START;
        end else begin
            state <= psmc_pkg::PSMC_RUN;
        end
    end

    // Configuration straps, captured only in the start state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_cfg     <= 3'h1;
            core_off     <= 1'b1;
            aux_two      <= 1'b0;
            aux_off      <= 1'b1;
            slew_latched <= `PSMC_SLEW_10;
            config_valid <= 1'b0;
        end else if (state == psmc_pkg::PSMC_START && soft_start) begin
            core_cfg     <= cfg_count(core_ch2_sense_pin, core_ch3_sense_pin,
                                      core_ch4_sense_pin);
            core_off     <= core_ch1_sense_pin;
            aux_two      <= !aux_ch2_sense_pin;
            aux_off      <= aux_ch1_sense_pin;
            slew_latched <= slew_select;
            config_valid <= 1'b0;
        end else if (state == psmc_pkg::PSMC_START) begin
            config_valid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode selection
    logic [1:0]             ps;
    psmc_pkg::psmc_phases_t next_core_phases;
    logic                   next_core_light;
    logic [1:0]             next_aux_phases;
    logic                   next_aux_light;

    // Undocumented 10 folds into 11 so the full count runs
    assign ps = (power_state_low_a == 1'b0 && power_state_low_b == 1'b0) ? `PSMC_PS_LIGHT :
                (power_state_low_a == 1'b0) ? `PSMC_PS_HALF : `PSMC_PS_FULL;

    // Core phase count and light-load choice per configuration
    always_comb begin
        next_core_phases = core_cfg;
        next_core_light  = 1'b0;
        unique case (ps)
            `PSMC_PS_LIGHT: begin
                next_core_phases = 3'h1;
                next_core_light  = 1'b1;
            end
            `PSMC_PS_HALF: begin
                if (core_cfg >= 3'h3) begin
                    next_core_phases = 3'h2;
                end else begin
                    next_core_phases = 3'h1;
                end
            end
            default: begin
                next_core_phases = core_cfg;
            end
        endcase
    end

    // Aux phase count and light-load choice
    always_comb begin
        next_aux_phases = aux_two ? 2'h2 : 2'h1;
        next_aux_light  = 1'b0;
        if (ps == `PSMC_PS_LIGHT) begin
            next_aux_phases = 2'h1;
            next_aux_light  = 1'b1;
        end else if (ps == `PSMC_PS_HALF) begin
            next_aux_phases = 2'h1;
        end
    end

    // Registered mode outputs; disabled outputs show zero phases
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_enable     <= 1'b0;
            core_phases     <= 3'h0;
            core_light_load <= 1'b0;
            aux_enable      <= 1'b0;
            aux_phases      <= 2'h0;
            aux_light_load  <= 1'b0;
        end else begin
            core_enable     <= config_valid && !core_off;
            core_phases     <= (config_valid && !core_off) ? next_core_phases : 3'h0;
            core_light_load <= config_valid && !core_off && next_core_light;
            aux_enable      <= config_valid && !aux_off;
            aux_phases      <= (config_valid && !aux_off) ? next_aux_phases : 2'h0;
            aux_light_load  <= config_valid && !aux_off && next_aux_light;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared slew divider
    logic [7:0] slew_cnt;
    logic [7:0] slew_period;
    logic       slew_en;

    // One divider for both outputs keeps their ramps identical
    always_comb begin
        unique case (slew_latched)
            `PSMC_SLEW_10:   slew_period = 8'(`PSMC_PER_10);
            `PSMC_SLEW_12P5: slew_period = 8'(`PSMC_PER_12P5);
            `PSMC_SLEW_15:   slew_period = 8'(`PSMC_PER_15);
            default:         slew_period = 8'(`PSMC_PER_20);
        endcase
    end

    // Enable pulse once per step period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            slew_cnt <= 8'h00;
            slew_en  <= 1'b0;
        end else if (slew_cnt >= slew_period - 8'h01) begin
            slew_cnt <= 8'h00;
            slew_en  <= 1'b1;
        end else begin
            slew_cnt <= slew_cnt + 8'h01;
            slew_en  <= 1'b0;
        end
    end

    // Core and aux ramps share the same enable
    psmc_ramp u_core_ramp (
        .clock    (clock),
        .rst_n    (rst_n),
        .step_en  (slew_en),
        .target   (core_target),
        .ref_code (core_ref)
    );

    psmc_ramp u_aux_ramp (
        .clock    (clock),
        .rst_n    (rst_n),
        .step_en  (slew_en),
        .target   (aux_target),
        .ref_code (aux_ref)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Adaptive low-side turn-off
    psmc_pkg::psmc_ls_e ls_state;
    logic [7:0]         diode_cnt;
    logic               discontinuous_conduction;

    assign discontinuous_conduction = core_light_load;

    // Low-side watch sequence: on, trip, then observe the diode window
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ls_state   <= psmc_pkg::PSMC_LS_IDLE;
            ls_off_req <= 1'b0;
            diode_cnt  <= 8'h00;
        end else begin
            unique case (ls_state)
                psmc_pkg::PSMC_LS_IDLE: begin
                    ls_off_req <= 1'b0;
                    diode_cnt  <= 8'h00;
                    if (discontinuous_conduction && ls_on) begin
                        ls_state <= psmc_pkg::PSMC_LS_ON;
                    end
                end
                psmc_pkg::PSMC_LS_ON: begin
                    if (!ls_on) begin
                        ls_state <= psmc_pkg::PSMC_LS_WATCH;
                    end else if (phase_below_thr) begin
                        ls_off_req <= 1'b1;
                    end
                end
                psmc_pkg::PSMC_LS_WATCH: begin
                    ls_off_req <= 1'b0;
                    if (body_diode && diode_cnt != 8'hFF) begin
                        diode_cnt <= diode_cnt + 8'h01;
                    end else begin
                        ls_state <= psmc_pkg::PSMC_LS_IDLE;
                    end
                end
                default: begin
                    ls_state <= psmc_pkg::PSMC_LS_IDLE;
                end
            endcase
        end
    end

    // Threshold nudged one step per low-side cycle to centre the diode window
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            zc_threshold <= `PSMC_THR_RESET;
        end else if (ls_state == psmc_pkg::PSMC_LS_WATCH && !body_diode) begin
            if (body_diode_reverse && zc_threshold != 8'h00) begin
                zc_threshold <= zc_threshold - 8'h01;
            end else if (diode_cnt > 8'(`PSMC_BODY_DIODE_CYC)
                         && zc_threshold != `PSMC_THR_MAX) begin
                zc_threshold <= zc_threshold + 8'h01;
            end else if (diode_cnt < 8'(`PSMC_BODY_DIODE_CYC)
                         && !body_diode_reverse && zc_threshold != 8'h00) begin
                zc_threshold <= zc_threshold - 8'h01;
            end
        end
    end
endmodule

// ===== verification/psmc_mode_checker.sv
// Port-level assertions for the mode controller
module psmc_mode_checker (
    input wire logic       clock,             // Clock
    input wire logic       rst_n,             // Reset
    input wire logic       soft_start,        // Strap window
    input wire logic       power_state_low_a, // Bit a
    input wire logic       power_state_low_b, // Bit b
    input wire logic       ls_on,             // Low gate
    input wire logic       phase_below_thr,   // Trip
    input wire logic       core_enable,       // Core on
    input wire logic [2:0] core_phases,       // Core count
    input wire logic       core_light_load,   // Core skip
    input wire logic       aux_enable,        // Aux on
    input wire logic [1:0] aux_phases,        // Aux count
    input wire logic       aux_light_load,    // Aux skip
    input wire logic [7:0] core_ref,          // Core ref
    input wire logic [1:0] slew_latched,      // Slew held
    input wire logic       ls_off_req,        // Low off
    input wire logic [7:0] zc_threshold,      // Threshold
    input wire logic       config_valid       // Config done
);
    logic [1:0] q;
    logic       rn;
    logic       lo;
    logic       hf;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Settle time after the strap window, so a fresh config is not misjudged
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            q <= 2'h0;
        else if (soft_start)
            q <= 2'h0;
        else if (q != 2'h3)
            q <= q + 2'h1;
    end
    // Decoded power-state codes; 10 counts as full
    assign rn = config_valid && q == 2'h3;
    assign lo = !power_state_low_a && !power_state_low_b;
    assign hf = !power_state_low_a && power_state_low_b;
    ////////////////////////////////////////////////////////////////////////////
    chk_core_light_one: assert property (
        rn && core_enable && lo |=> core_light_load && core_phases == 3'h1)
        else $error("core light load mode missing");
    chk_core_half_ccm: assert property (
        rn && core_enable && hf |=> !core_light_load && core_phases inside {3'h1, 3'h2})
        else $error("core half mode wrong");
    chk_core_off_idle: assert property (
        rn && !core_enable |=> core_phases == 3'h0 && !core_light_load)
        else $error("disabled core shows activity");
    chk_aux_light_one: assert property (
        rn && aux_enable && lo |=> aux_light_load && aux_phases == 2'h1)
        else $error("aux light load mode missing");
    chk_aux_half_one: assert property (
        rn && aux_enable && hf |=> !aux_light_load && aux_phases == 2'h1)
        else $error("aux half mode wrong");
    chk_config_valid_rise: assert property ($fell(soft_start) |=> config_valid)
        else $error("config valid late");
    chk_slew_held: assert property (rn |-> $stable(slew_latched))
        else $error("slew selection moved");
    chk_ref_single_step: assert property (
        core_ref > $past(core_ref) |-> core_ref == $past(core_ref) + 8'h01)
        else $error("reference rose by more than one code");
    chk_low_side_off: assert property (
        core_light_load && ls_on && $past(ls_on) && phase_below_thr |=> ls_off_req)
        else $error("low side not released at trip");
    chk_thr_unit_step: assert property (
        $changed(zc_threshold) |-> zc_threshold == $past(zc_threshold) + 8'h01
        || zc_threshold == $past(zc_threshold) - 8'h01)
        else $error("threshold jumped");
    cover property (rn && core_light_load);
    cover property (ls_off_req);
    cover property ($changed(zc_threshold));
endmodule
bind psmc_mode_ctrl psmc_mode_checker i_psmc_mode_checker (
    .clock, .rst_n, .soft_start, .power_state_low_a, .power_state_low_b, .ls_on,
    .phase_below_thr, .core_enable, .core_phases, .core_light_load, .aux_enable,
    .aux_phases, .aux_light_load, .core_ref, .slew_latched, .ls_off_req, .zc_threshold,
    .config_valid
);

// ===== verification/psmc_ps_host.sv
// Host model that delivers the two power-state bits
module psmc_ps_host (
    input  wire logic       clock,             // Clock
    input  wire logic       rst_n,             // Reset
    input  wire logic       req,               // New command
    input  wire logic [1:0] cmd,               // Bits a and b
    input  wire logic [3:0] lag,               // Delivery delay
    output logic            power_state_low_a, // First bit
    output logic            power_state_low_b  // Second bit
);
    logic [1:0] pend;
    logic [3:0] cnt;
    // Falling-edge delivery after a lag, so slow links are exercised too
    always_ff @(negedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {power_state_low_a, power_state_low_b} <= 2'h3;
            pend <= 2'h3;
            cnt <= 4'h0;
        end else if (req) begin
            pend <= cmd;
            cnt <= lag + 4'h1;
        end else if (cnt == 4'h1) begin
            {power_state_low_a, power_state_low_b} <= pend;
            cnt <= 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// ===== verification/psmc_mode_ctrl_tb.sv
// Self-checking bench for the phase shedding mode controller
module psmc_mode_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       rst_n;
    logic       clock = 1'b0, soft_start = 1'b0, req = 1'b0, ls_on = 1'b0;
    logic       phase_below_thr = 1'b0, body_diode = 1'b0, body_diode_reverse = 1'b0;
    logic       core_ch1_sense_pin = 1'b0, core_ch2_sense_pin = 1'b0;
    logic       core_ch3_sense_pin = 1'b0, core_ch4_sense_pin = 1'b0;
    logic       aux_ch1_sense_pin = 1'b0, aux_ch2_sense_pin = 1'b0;
    logic       power_state_low_a, power_state_low_b, core_enable, core_light_load;
    logic       aux_enable, aux_light_load, ls_off_req, config_valid;
    logic [1:0] slew_select = 2'h0, cmd = 2'h3, psv = 2'h3, aux_phases, slew_latched;
    logic [2:0] core_phases;
    logic [3:0] lag = 4'h0;
    logic [7:0] core_target = 8'h00, aux_target = 8'h00, core_ref, aux_ref, zc_threshold;
    logic [7:0] et = 8'h80;
    int         fails = 0, checks_done = 0, k;
    int         per[4] = '{62, 50, 41, 31};
    psmc_mode_ctrl i_psmc_mode_ctrl (.*);
    psmc_ps_host i_psmc_ps_host (.clock, .rst_n, .req, .cmd, .lag, .power_state_low_a,
        .power_state_low_b);
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Packed {enable, phases, light}; a count of 0 means the output is off
    function automatic logic [7:0] exp_mode(input int n, input logic [1:0] ps);
        if (n == 0) return 8'h00;
        if (ps[1]) return {4'h1, 3'(n), 1'b0};
        if (ps[0]) return {4'h1, (n > 2) ? 3'h2 : 3'h1, 1'b0};
        return 8'h13;
    endfunction
    task automatic chk_modes(input int n, input int m);
        chk({3'h0, core_enable, core_phases, core_light_load}, exp_mode(n, psv), "core");
        chk({3'h0, aux_enable, 1'b0, aux_phases, aux_light_load}, exp_mode(m, psv), "aux");
    endtask
    task automatic set_ps(input logic [1:0] ps, input logic [3:0] l);
        cmd <= ps;
        lag <= l;
        req <= 1'b1;
        @(negedge clock);
        req <= 1'b0;
        repeat (l + 2) @(negedge clock);
        psv = ps;
    endtask
    // Contiguous ties from the top channel down set the phase count
    task automatic start(input int n, input int m, input logic [1:0] s);
        soft_start <= 1'b1;
        {core_ch1_sense_pin, core_ch2_sense_pin, core_ch3_sense_pin, core_ch4_sense_pin}
            <= {n == 0, n < 2, n < 3, n < 4};
        {aux_ch1_sense_pin, aux_ch2_sense_pin} <= {m == 0, m < 2};
        slew_select <= s;
        repeat (2) @(negedge clock);
        soft_start <= 1'b0;
        repeat (3) @(negedge clock);
        chk({7'h0, config_valid}, 8'h01, "config valid");
        chk({6'h0, slew_latched}, {6'h0, s}, "slew latch");
        chk_modes(n, m);
    endtask
    task automatic ls_cycle(input int d, input logic rev);
        ls_on <= 1'b1;
        @(negedge clock);
        phase_below_thr <= 1'b1;
        repeat (2) @(negedge clock);
        chk({7'h0, ls_off_req}, 8'h01, "low side off");
        ls_on <= 1'b0;
        phase_below_thr <= 1'b0;
        body_diode <= 1'b1;
        body_diode_reverse <= rev;
        repeat (d) @(negedge clock);
        body_diode <= 1'b0;
        // Spike outlasts the diode by one cycle so the closing edge sees it
        @(negedge clock);
        body_diode_reverse <= 1'b0;
        repeat (2) @(negedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        void'($urandom(74));
        repeat (5) @(negedge clock);
        chk(zc_threshold, 8'h80, "reset threshold");
        chk({7'h0, core_enable}, 8'h00, "reset enable");
        rst_n <= 1'b1;
        // Every configuration against every code, then strap noise after start-up
        for (int n = 0; n < 5; n++) begin
            for (int m = 0; m < 3; m++) begin
                start(n, m, 2'(n));
                for (int p = 0; p < 4; p++) begin
                    set_ps(2'(p), 4'($urandom_range(3)));
                    chk_modes(n, m);
                end
                {core_ch1_sense_pin, core_ch2_sense_pin, core_ch3_sense_pin} <= 3'($urandom);
                {aux_ch1_sense_pin, aux_ch2_sense_pin} <= 2'($urandom);
                slew_select <= 2'($urandom);
                repeat (3) @(negedge clock);
                chk_modes(n, m);
                chk({6'h0, slew_latched}, {6'h0, 2'(n)}, "slew hold");
            end
        end
        // Random codes with random link delays
        start(3, 2, 2'h1);
        for (int i = 0; i < 40; i++) begin
            set_ps(2'($urandom), 4'($urandom_range(7)));
            chk_modes(3, 2);
        end
        // Ramp up at each slew choice, then a downward jump
        for (int s = 0; s < 4; s++) begin
            start(4, 2, 2'(s));
            core_target <= 8'h04;
            aux_target <= 8'h04;
            k = 0;
            while (core_ref !== 8'h04 && k < 400) begin
                @(negedge clock);
                k++;
                chk(aux_ref, core_ref, "aux ref");
            end
            if (k == 400) begin
                fails++;
                report_and_stop();
            end
            chk(8'(k >= 2 * per[s] && k <= 4 * per[s] + 4), 8'h01, "slew time");
            core_target <= 8'h01;
            aux_target <= 8'h01;
            @(negedge clock);
            chk(core_ref, 8'h01, "down step");
        end
        // Long diode, short diode, then a long diode with a reversed spike
        set_ps(2'h0, 4'h0);
        for (int i = 0; i < 3; i++) begin
            ls_cycle(i == 1 ? 1 : 8, i == 2);
            et = (i == 0) ? et + 8'h01 : et - 8'h01;
            chk(zc_threshold, et, "threshold");
        end
        report_and_stop();
    end
endmodule
